// ==== vtcl_pkg.sv ====
package vtcl_pkg;

    // VC-4 column geometry
    localparam logic [8:0] VTCL_COL_FIRST = 9'h001;
    localparam logic [8:0] VTCL_COL_TUG_FIRST = 9'h004;
    localparam logic [8:0] VTCL_COL_GRP_FIRST = 9'h00A;
    localparam logic [8:0] VTCL_COL_LAST = 9'h105;
    localparam logic [8:0] VTCL_COL_SAT = 9'h1FF;

    // Tributary address ranges
    localparam logic [1:0] VTCL_NUM_K = 2'h3;
    localparam logic [2:0] VTCL_NUM_L = 3'h7;
    localparam logic [1:0] VTCL_NUM_M = 2'h3;
    localparam logic [6:0] VTCL_TU3_COLS = 7'h56;
    localparam logic [3:0] VTCL_TU2_COLS = 4'hC;
    localparam logic [2:0] VTCL_TU12_COLS = 3'h4;

    // PDH frames: four bit-interleaved columns, payload row window
    localparam logic [1:0] VTCL_PDH_LAST_COL = 2'h3;
    localparam logic [9:0] VTCL_E2_ROW_FIRST = 10'h004;
    localparam logic [9:0] VTCL_E2_ROW_LAST = 10'h0D4;
    localparam logic [9:0] VTCL_E3_ROW_FIRST = 10'h004;
    localparam logic [9:0] VTCL_E3_ROW_LAST = 10'h180;
    localparam logic [9:0] VTCL_E4_ROW_FIRST = 10'h005;
    localparam logic [9:0] VTCL_E4_ROW_LAST = 10'h2DC;

    // Supervision defaults
    localparam logic [3:0] VTCL_FAIL_ROWS = 4'h8;
    localparam logic [15:0] VTCL_P_SAT = 16'hFFFF;
    localparam logic [3:0] VTCL_REI_SAT = 4'hF;

    typedef enum logic [1:0] {
        VTCL_TU3 = 2'b00,
        VTCL_TU2 = 2'b01,
        VTCL_TU12 = 2'b10
    } vtcl_mode_t;

    typedef enum logic [1:0] {
        VTCL_PDH_E2 = 2'b00,
        VTCL_PDH_E3 = 2'b01,
        VTCL_PDH_E4 = 2'b10
    } vtcl_pdh_fmt_t;

    typedef struct packed {
        logic valid;
        logic first;
    } vtcl_strobe_t;

    typedef struct packed {
        logic [1:0] k;
        logic [2:0] l;
        logic [1:0] m;
    } vtcl_addr_t;

    typedef struct packed {
        logic valid;
        logic no_tug;
        logic stuff;
        vtcl_addr_t addr;
        logic [6:0] x;
    } vtcl_loc_t;

    typedef struct packed {
        logic valid;
        logic payload;
        logic [2:0] trib;
        logic [9:0] row;
    } vtcl_pdh_loc_t;

    // Boolean d/c/f/a classes, integer p class and integer REI action
    typedef struct packed {
        logic d_row_len;
        logic c_row_len;
        logic f_row_len;
        logic a_ais;
        logic n_row_len;
        logic [15:0] p_err_rows;
        logic [3:0] a_rei;
    } vtcl_sup_t;

endpackage : vtcl_pkg

// ==== vtcl_pdh_locator.sv ====
`timescale 1ns/10ps
module vtcl_pdh_locator
    import vtcl_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_srst,
    input wire vtcl_strobe_t i_bit,
    input wire vtcl_pdh_fmt_t i_fmt,
    output vtcl_pdh_loc_t o_loc
);

    function automatic logic [9:0] vtcl_row_first(input vtcl_pdh_fmt_t fmt);
        case (fmt)
            VTCL_PDH_E3: vtcl_row_first = VTCL_E3_ROW_FIRST;
            VTCL_PDH_E4: vtcl_row_first = VTCL_E4_ROW_FIRST;
            default: vtcl_row_first = VTCL_E2_ROW_FIRST;
        endcase
    endfunction : vtcl_row_first

    function automatic logic [9:0] vtcl_row_last(input vtcl_pdh_fmt_t fmt);
        case (fmt)
            VTCL_PDH_E3: vtcl_row_last = VTCL_E3_ROW_LAST;
            VTCL_PDH_E4: vtcl_row_last = VTCL_E4_ROW_LAST;
            default: vtcl_row_last = VTCL_E2_ROW_LAST;
        endcase
    endfunction : vtcl_row_last

    logic [1:0] col_q;
    logic [1:0] col_d;
    logic [9:0] row_q;
    logic [9:0] row_d;
    logic in_payload;

    // One tributary per bit, cycling through the four columns
    assign col_d = i_bit.first ? 2'h0 : col_q + 2'h1; // [R9]
    assign row_d = i_bit.first ? 10'h001 :
                   (col_q == VTCL_PDH_LAST_COL) ? row_q + 10'h001 : row_q;
    assign in_payload = (row_d >= vtcl_row_first(i_fmt)) &&
                        (row_d <= vtcl_row_last(i_fmt)); // [R6] [R7] [R8]

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            col_q <= 2'h3;
            row_q <= 10'h000;
            o_loc <= '0;
        end else begin
            o_loc.valid <= i_bit.valid;
            if (i_bit.valid) begin
                col_q <= col_d;
                row_q <= row_d;
                o_loc.payload <= in_payload;
                o_loc.trib <= {1'b0, col_d} + 3'h1; // [R6] [R7] [R8]
                o_loc.row <= row_d;
            end
        end
    end

endmodule : vtcl_pdh_locator

// ==== vtcl_locator.sv ====
`timescale 1ns/10ps
// What this block does
// [R1] TUG-3 k owns VC-4 columns 3+k, 6+k, ... up to 258+k.
// [R2] Each TUG-3 holds TUG-2 groups 1..7, each holding TU-12s 1..3.
// [R3] TU-12 (K,L,M) column X is 10+(K-1)+3(L-1)+21(M-1)+63(X-1), X 1..4.
// [R4] TU-2 (K,L,0) column X is 10+(K-1)+3(L-1)+21(X-1), X 1..12.
// [R5] TU-3 (K,0,0) column X is 4+(K-1)+3(X-1), X 1..86.
// [R6] 8448 kbit/s frame: column n, rows 4..212 carry 2 Mbit/s tributary n.
// [R7] 34368 kbit/s frame: column n, rows 4..384 carry 8 Mbit/s tributary n.
// [R8] 139264 kbit/s frame: column n, rows 5..732 carry 34 Mbit/s tributary n.
// [R9] PDH formats interleave per bit; SDH structures interleave per byte.
// [R10] Supervision names: class letter d, c, f, a, p or n, then kind.
// [R11] d, c, f and most a are single bits; p and REI action are integers.
// [R12] Connection point id is the access point number extended by the address.
// [R13] Each payload column reports its owner address; columns below 4 flagged.
module vtcl_locator
    import vtcl_pkg::*;
#(
    parameter int AP_W = 8
)
(
    input wire logic i_clock,
    input wire logic i_srst,
    input wire vtcl_strobe_t i_byte,
    input wire vtcl_mode_t [2:0] i_mode,
    input wire logic [AP_W-1:0] i_ap_num,
    input wire logic i_srv_ais,
    input wire logic i_period,
    input wire vtcl_strobe_t i_bit,
    input wire vtcl_pdh_fmt_t i_pdh_fmt,
    output vtcl_loc_t o_loc,
    output logic [AP_W+6:0] o_cp_id,
    output vtcl_sup_t o_sup,
    output vtcl_pdh_loc_t o_pdh
);

    function automatic vtcl_mode_t vtcl_mode_of(input vtcl_mode_t [2:0] modes,
                                                input logic [1:0] k);
        case (k)
            2'h2: vtcl_mode_of = modes[1];
            2'h3: vtcl_mode_of = modes[2];
            default: vtcl_mode_of = modes[0];
        endcase
    endfunction : vtcl_mode_of

    // Counters hold the position of the last accepted column
    logic [8:0] col_q;
    logic [1:0] k_q;
    logic [2:0] l_q;
    logic [1:0] m_q;
    logic [2:0] x12_q;
    logic [3:0] tu2x_q;
    logic [6:0] tu3x_q;
    logic row_seen_q;
    logic [3:0] fail_cnt_q;
    logic [3:0] per_err_q;

    logic [8:0] col_n;
    logic in_tug;
    logic at_tug_first;
    logic at_grp_first;
    logic in_grp;
    logic k_wrap;
    logic g_step;
    logic l_wrap;
    logic m_wrap;
    logic [1:0] k_n;
    logic [2:0] l_n;
    logic [1:0] m_n;
    logic [2:0] x12_n;
    logic [3:0] tu2x_n;
    logic [6:0] tu3x_n;
    vtcl_mode_t mode_n;
    vtcl_addr_t addr_n;
    logic [6:0] x_n;
    logic stuff_n;
    logic row_bad;
    logic row_good;
    logic cause_n;

    // Column count per byte; holds at the top if the row start never comes
    assign col_n = i_byte.first ? VTCL_COL_FIRST :
                   (col_q == VTCL_COL_SAT) ? col_q : col_q + 9'h001; // [R9]
    assign in_tug = (col_n >= VTCL_COL_TUG_FIRST) && (col_n <= VTCL_COL_LAST); // [R13]
    assign at_tug_first = (col_n == VTCL_COL_TUG_FIRST);
    assign at_grp_first = (col_n == VTCL_COL_GRP_FIRST);
    assign in_grp = in_tug && (col_n > VTCL_COL_GRP_FIRST);
    assign k_wrap = (k_q == VTCL_NUM_K);
    assign g_step = in_grp && k_wrap;
    assign l_wrap = g_step && (l_q == VTCL_NUM_L);
    assign m_wrap = l_wrap && (m_q == VTCL_NUM_M);

    // TUG-3 number cycles 1..3 on every column from column 4 to column 261
    assign k_n = !in_tug ? 2'h0 :
                 at_tug_first ? 2'h1 :
                 k_wrap ? 2'h1 : k_q + 2'h1; // [R1]
    assign tu3x_n = !in_tug ? 7'h00 :
                    at_tug_first ? 7'h01 :
                    k_wrap ? tu3x_q + 7'h01 : tu3x_q; // [R5]

    // Group numbering starts at column 10; L steps once per three columns
    assign l_n = !(in_grp || at_grp_first) ? 3'h0 :
                 at_grp_first ? 3'h1 :
                 !g_step ? l_q :
                 (l_q == VTCL_NUM_L) ? 3'h1 : l_q + 3'h1; // [R2]
    assign m_n = !(in_grp || at_grp_first) ? 2'h0 :
                 at_grp_first ? 2'h1 :
                 !l_wrap ? m_q :
                 (m_q == VTCL_NUM_M) ? 2'h1 : m_q + 2'h1; // [R2]
    assign tu2x_n = !(in_grp || at_grp_first) ? 4'h0 :
                    at_grp_first ? 4'h1 :
                    l_wrap ? tu2x_q + 4'h1 : tu2x_q; // [R4]
    assign x12_n = !(in_grp || at_grp_first) ? 3'h0 :
                   at_grp_first ? 3'h1 :
                   m_wrap ? x12_q + 3'h1 : x12_q; // [R3]

    // Per-TUG-3 structure decides which digits and which column index apply
    assign mode_n = vtcl_mode_of(i_mode, k_n);
    assign stuff_n = in_tug && (mode_n != VTCL_TU3) && (col_n < VTCL_COL_GRP_FIRST);
    assign addr_n.k = k_n; // [R13]
    assign addr_n.l = (mode_n == VTCL_TU3 || stuff_n) ? 3'h0 : l_n; // [R4] [R5]
    assign addr_n.m = (mode_n == VTCL_TU12 && !stuff_n) ? m_n : 2'h0; // [R3] [R4]
    assign x_n = stuff_n ? 7'h00 :
                 (mode_n == VTCL_TU3) ? tu3x_n :
                 (mode_n == VTCL_TU2) ? {3'h0, tu2x_n} : {4'h0, x12_n};

    // Row length check: a row start must follow exactly the last column
    assign row_bad = i_byte.valid && i_byte.first && row_seen_q &&
                     (col_q != VTCL_COL_LAST);
    assign row_good = i_byte.valid && i_byte.first && row_seen_q &&
                      (col_q == VTCL_COL_LAST);
    // Defect is not reported as a cause while the server signals AIS
    assign cause_n = o_sup.d_row_len && !i_srv_ais;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            col_q <= VTCL_COL_SAT;
            k_q <= 2'h0;
            l_q <= 3'h0;
            m_q <= 2'h0;
            x12_q <= 3'h0;
            tu2x_q <= 4'h0;
            tu3x_q <= 7'h00;
            row_seen_q <= 1'b0;
            o_loc <= '0;
            o_cp_id <= '0;
        end else begin
            o_loc.valid <= i_byte.valid;
            if (i_byte.valid) begin
                col_q <= col_n;
                k_q <= k_n;
                l_q <= l_n;
                m_q <= m_n;
                x12_q <= x12_n;
                tu2x_q <= tu2x_n;
                tu3x_q <= tu3x_n;
                row_seen_q <= row_seen_q || i_byte.first;
                o_loc.no_tug <= !in_tug; // [R13]
                o_loc.stuff <= stuff_n;
                o_loc.addr <= addr_n; // [R13]
                o_loc.x <= x_n;
                o_cp_id <= {i_ap_num, addr_n}; // [R12]
            end
        end
    end

    // Supervision: one-bit d, c, f, a and n; integer p and REI
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_sup <= '0;
            fail_cnt_q <= 4'h0;
            per_err_q <= 4'h0;
        end else begin
            o_sup.n_row_len <= row_bad; // [R10]
            if (row_bad) begin
                o_sup.d_row_len <= 1'b1; // [R11]
            end else if (row_good) begin
                o_sup.d_row_len <= 1'b0;
            end
            o_sup.c_row_len <= cause_n; // [R10] [R11]
            if (!cause_n) begin
                fail_cnt_q <= 4'h0;
                o_sup.f_row_len <= 1'b0;
            end else if (i_byte.valid && i_byte.first) begin
                if (fail_cnt_q == VTCL_FAIL_ROWS) begin
                    o_sup.f_row_len <= 1'b1; // [R11]
                end else begin
                    fail_cnt_q <= fail_cnt_q + 4'h1;
                end
            end
            o_sup.a_ais <= o_sup.f_row_len; // [R11]
            if (row_bad && o_sup.p_err_rows != VTCL_P_SAT) begin
                o_sup.p_err_rows <= o_sup.p_err_rows + 16'h0001; // [R11]
            end
            // A period tick loads the errored-row count; an error in that cycle is kept
            if (i_period) begin
                o_sup.a_rei <= per_err_q; // [R11]
                per_err_q <= row_bad ? 4'h1 : 4'h0;
            end else if (row_bad && per_err_q != VTCL_REI_SAT) begin
                per_err_q <= per_err_q + 4'h1;
            end
        end
    end

    vtcl_pdh_locator u_pdh (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_bit(i_bit),
        .i_fmt(i_pdh_fmt),
        .o_loc(o_pdh)
    );

endmodule : vtcl_locator

// ==== vtcl_locator_properties.sv ====
`timescale 1ns/10ps
module vtcl_locator_properties
    import vtcl_pkg::*;
#(
    parameter int AP_W = 8
)
(
    input wire logic i_clock,
    input wire logic i_srst,
    input wire vtcl_strobe_t i_byte,
    input wire vtcl_mode_t [2:0] i_mode,
    input wire logic [AP_W-1:0] i_ap_num,
    input wire logic i_srv_ais,
    input wire logic i_period,
    input wire vtcl_strobe_t i_bit,
    input wire vtcl_pdh_fmt_t i_pdh_fmt,
    input wire vtcl_loc_t o_loc,
    input wire logic [AP_W+6:0] o_cp_id,
    input wire vtcl_sup_t o_sup,
    input wire vtcl_pdh_loc_t o_pdh
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_srst);
    sequence row_start_s;
        i_byte.valid && i_byte.first;
    endsequence
    sequence bad_row_s;
        row_start_s ##1 o_sup.n_row_len;
    endsequence
    loc_pulse_a: assert property (i_byte.valid |=> o_loc.valid)
        else $error("byte without locator answer");
    loc_idle_a: assert property (!i_byte.valid |=> !o_loc.valid)
        else $error("locator answer without byte");
    row_start_a: assert property (row_start_s |=> o_loc.no_tug)
        else $error("column 1 not flagged");
    cp_id_a: assert property (i_byte.valid |=> o_cp_id[AP_W+6:7] == $past(i_ap_num))
        else $error("access point not in identifier");
    tu3_addr_a: assert property (o_loc.valid && !o_loc.no_tug
        && i_mode[o_loc.addr.k-2'h1] == VTCL_TU3 |-> o_loc.addr.l == 3'h0
        && o_loc.addr.m == 2'h0 && o_loc.x inside {[7'h01:7'h56]})
        else $error("bad whole tributary address");
    tu12_x_a: assert property (o_loc.valid && !o_loc.no_tug && !o_loc.stuff
        && i_mode[o_loc.addr.k-2'h1] == VTCL_TU12
        |-> o_loc.addr.m != 2'h0 && o_loc.x inside {[7'h01:7'h04]})
        else $error("bad small tributary address");
    pdh_first_a: assert property (i_bit.valid && i_bit.first |=> o_pdh.valid
        && o_pdh.trib == 3'h1 && o_pdh.row == 10'h001 && !o_pdh.payload)
        else $error("frame start not at first bit");
    cause_mask_a: assert property (1'b1 |=>
        o_sup.c_row_len == $past(o_sup.d_row_len && !i_srv_ais))
        else $error("cause not masked defect");
    ais_follow_a: assert property (1'b1 |=> o_sup.a_ais == $past(o_sup.f_row_len))
        else $error("action does not follow failure");
    bad_row_a: assert property (bad_row_s |-> o_sup.d_row_len)
        else $error("anomaly without defect");
endmodule : vtcl_locator_properties

bind vtcl_locator vtcl_locator_properties #(.AP_W(AP_W)) u_props (.i_clock(i_clock),
    .i_srst(i_srst), .i_byte(i_byte), .i_mode(i_mode), .i_ap_num(i_ap_num),
    .i_srv_ais(i_srv_ais), .i_period(i_period), .i_bit(i_bit), .i_pdh_fmt(i_pdh_fmt),
    .o_loc(o_loc), .o_cp_id(o_cp_id), .o_sup(o_sup), .o_pdh(o_pdh));

// ==== vtcl_aligner_model.sv ====
`timescale 1ns/10ps
module vtcl_aligner_model
    import vtcl_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_run,
    input wire logic i_slow,
    input wire logic [8:0] i_row_len,
    output vtcl_strobe_t o_byte,
    output logic [8:0] o_col
);
    logic [8:0] col_q;
    logic phase_q;
    logic byte_valid;
    // A slow aligner offers a byte only every second cycle
    assign byte_valid = i_run && (!i_slow || phase_q);
    assign o_byte = {byte_valid, byte_valid && (col_q == 9'h001)};
    assign o_col = col_q;
    // Phase restarts while idle so it never stays unknown
    always_ff @(posedge i_clock) begin
        if (!i_run) begin
            phase_q <= 1'b0;
            col_q <= 9'h001;
        end else begin
            phase_q <= !phase_q;
            if (byte_valid) begin
                col_q <= (col_q == i_row_len) ? 9'h001 : col_q + 9'h001;
            end
        end
    end
endmodule : vtcl_aligner_model

// ==== tb_vtcl_locator.sv ====
`timescale 1ns/10ps
module tb_vtcl_locator
    import vtcl_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic run = 1'b0;
    logic slow = 1'b0;
    logic [8:0] row_len = 9'h105;
    logic [8:0] col;
    vtcl_strobe_t byte_s;
    vtcl_strobe_t bit_s = '0;
    vtcl_mode_t [2:0] mode = '{VTCL_TU3, VTCL_TU3, VTCL_TU3};
    logic [7:0] ap = 8'hA5;
    logic [7:0] ap_q;
    logic ais = 1'b0;
    logic period = 1'b0;
    vtcl_pdh_fmt_t fmt = VTCL_PDH_E2;
    vtcl_loc_t loc;
    vtcl_loc_t exp_q;
    logic [14:0] cp;
    vtcl_sup_t sup;
    vtcl_pdh_loc_t pdh;
    int n_fail = 0;
    int tests_run = 0;
    int n_loc = 0;
    int n_bad = 0;

    vtcl_aligner_model u_align (.i_clock(clk), .i_run(run), .i_slow(slow),
        .i_row_len(row_len), .o_byte(byte_s), .o_col(col));
    vtcl_locator #(.AP_W(8)) i_dut (.i_clock(clk), .i_srst(srst), .i_byte(byte_s),
        .i_mode(mode), .i_ap_num(ap), .i_srv_ais(ais), .i_period(period), .i_bit(bit_s),
        .i_pdh_fmt(fmt), .o_loc(loc), .o_cp_id(cp), .o_sup(sup), .o_pdh(pdh));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    function automatic vtcl_loc_t exp_loc(input logic [8:0] c);
        vtcl_loc_t e;
        int d;
        e = '0;
        e.valid = 1'b1;
        d = int'(c) - 10;
        if (c < 9'h004 || c > 9'h105) begin
            e.no_tug = 1'b1;
            return e;
        end
        e.addr.k = 2'((c - 9'h004) % 3 + 1);
        if (mode[e.addr.k-2'h1] == VTCL_TU3) begin
            e.x = 7'((c - 9'h004) / 3 + 1);
        end else if (d < 0) begin
            e.stuff = 1'b1;
        end else begin
            e.addr.l = 3'((d / 3) % 7 + 1);
            e.x = 7'(d / 21 + 1);
            if (mode[e.addr.k-2'h1] == VTCL_TU12) begin
                e.addr.m = 2'((d / 21) % 3 + 1);
                e.x = 7'(d / 63 + 1);
            end
        end
        return e;
    endfunction : exp_loc

    // Expectation is frozen at the byte's edge, compared once it has settled
    always @(posedge clk) begin
        if (byte_s.valid === 1'b1) begin
            exp_q <= exp_loc(col);
            ap_q <= ap;
        end
    end
    always @(negedge clk) begin
        if (loc.valid === 1'b1) begin
            n_loc++;
            cmp("locator", 32'(exp_q), 32'(loc));
            cmp("cp_id", 32'({ap_q, exp_q.addr}), 32'(cp));
        end
        // One-cycle anomaly pulses are counted while they stand
        if (sup.n_row_len === 1'b1) n_bad++;
    end

    task automatic run_bytes(input int n, input logic [8:0] len);
        int k;
        k = 0;
        row_len = len;
        run = 1'b1;
        while (k < n) begin
            @(posedge clk);
            if (byte_s.valid === 1'b1) k++;
        end
        @(negedge clk);
        run = 1'b0;
    endtask : run_bytes

    task automatic t_sdh(input vtcl_mode_t m3, m2, m1, input logic sl, input logic [7:0] a);
        int seen;
        mode = '{m3, m2, m1};
        slow = sl;
        ap = a;
        seen = n_loc;
        run_bytes(2 * 261 + 1, 9'h105);
        repeat (2) @(negedge clk);
        cmp("loc count", 32'h20B, 32'(n_loc - seen));
    endtask : t_sdh

    task automatic t_sup();
        int seen;
        srst = 1'b1;
        @(negedge clk);
        srst = 1'b0;
        slow = 1'b0;
        seen = n_bad;
        run_bytes(12 * 20, 9'h014);
        repeat (2) @(negedge clk);
        cmp("p_err_rows", 32'h0B, 32'(sup.p_err_rows));
        cmp("n_row_len", 32'h0B, 32'(n_bad - seen));
        cmp("d c f a", 32'hF, 32'({sup.d_row_len, sup.c_row_len, sup.f_row_len, sup.a_ais}));
        period = 1'b1;
        @(negedge clk);
        period = 1'b0;
        @(negedge clk);
        cmp("a_rei", 32'h0B, 32'(sup.a_rei));
        ais = 1'b1;
        repeat (2) @(negedge clk);
        cmp("masked cause", 32'h0, 32'(sup.c_row_len));
        ais = 1'b0;
        run_bytes(2 * 261 + 1, 9'h105);
        repeat (3) @(negedge clk);
        cmp("cleared d c f", 32'h0, 32'({sup.d_row_len, sup.c_row_len, sup.f_row_len}));
        cmp("p_err_rows", 32'h0C, 32'(sup.p_err_rows));
    endtask : t_sup

    task automatic t_pdh(input vtcl_pdh_fmt_t f, input int lo, input int last);
        int row;
        logic [31:0] want;
        fmt = f;
        for (int i = 0; i < (last + 1) * 4; i++) begin
            bit_s = {1'b1, i == 0};
            @(negedge clk);
            row = i / 4 + 1;
            want = {17'h0, 1'b1, row >= lo && row <= last, 3'(i % 4 + 1), 10'(row)};
            cmp("pdh", want, 32'(pdh));
        end
        bit_s = '0;
        @(negedge clk);
    endtask : t_pdh

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (10) @(negedge clk);
        srst = 1'b0;
        t_sdh(VTCL_TU3, VTCL_TU3, VTCL_TU3, 1'b0, 8'hA5);
        t_sdh(VTCL_TU12, VTCL_TU12, VTCL_TU12, 1'b0, 8'h3C);
        t_sdh(VTCL_TU3, VTCL_TU12, VTCL_TU2, 1'b1, 8'hFF);
        t_sup();
        t_pdh(VTCL_PDH_E2, 4, 212);
        t_pdh(VTCL_PDH_E3, 4, 384);
        t_pdh(VTCL_PDH_E4, 5, 732);
        conclude();
    end

    initial begin
        #400000;
        n_fail++;
        conclude();
    end
endmodule : tb_vtcl_locator
